// file: pldc_map.vh
`ifndef PLDC_MAP_VH
`define PLDC_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PLDC_OFS_OD_EN 8'h00
`define PLDC_OFS_OD_DIS 8'h04
`define PLDC_OFS_OD_STAT 8'h08
`define PLDC_OFS_PU_DIS 8'h0c
`define PLDC_OFS_PU_EN 8'h10
`define PLDC_OFS_PU_STAT 8'h14
`define PLDC_OFS_PA_SEL 8'h18
`define PLDC_OFS_PB_SEL 8'h1c
`define PLDC_OFS_PAB_STAT 8'h20
`define PLDC_OFS_DW_EN 8'h24
`define PLDC_OFS_DW_DIS 8'h28
`define PLDC_OFS_DW_STAT 8'h2c
`define PLDC_OFS_OUT_LVL 8'h30
// ----------------------------------------
// reset values
// ----------------------------------------
`define PLDC_RST_OD 32'h00000000
`define PLDC_RST_PU_ON 32'hffffffff
`define PLDC_RST_PB 32'h00000000
`define PLDC_RST_DW 32'h00000000
`define PLDC_RST_LVL 32'h00000000
// ----------------------------------------
// bus widths and answers
// ----------------------------------------
`define PLDC_AW 8
`define PLDC_DW 32
`define PLDC_RESP_OKAY 2'b00
`define PLDC_RESP_SLVERR 2'b10
`endif

// file: pldc_setclr.v
`timescale 1ns/1ns
// ----------------------------------------
// per-line set/clear state register
// ----------------------------------------
module pldc_setclr #(
  parameter [31:0] RST_VAL = 32'h00000000
) (
  input wire ref_clk_in, // system clock
  input wire rstn_in, // synchronous reset, active low
  input wire [31:0] set_in, // one-cycle set mask
  input wire [31:0] clr_in, // one-cycle clear mask
  output reg [31:0] state_out // per-line state
);
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_line
      // only one of set/clear is ever pulsed per write
      always @(posedge ref_clk_in) begin
        if (!rstn_in) begin
          state_out[i] <= RST_VAL[i];
        end else if (set_in[i]) begin
          state_out[i] <= 1'b1;
        end else if (clr_in[i]) begin
          state_out[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// file: pldc_axil_wr.v
`timescale 1ns/1ns
`include "pldc_map.vh"
// ----------------------------------------
// axi4-lite write channel capture
// ----------------------------------------
module pldc_axil_wr (
  input wire ref_clk_in, // system clock
  input wire rstn_in, // synchronous reset, active low
  input wire [`PLDC_AW-1:0] awaddr_in, // write address
  input wire awvalid_in, // write address valid
  output reg awready_out, // write address ready
  input wire [31:0] wdata_in, // write data
  input wire [3:0] wstrb_in, // byte strobes
  input wire wvalid_in, // write data valid
  output reg wready_out, // write data ready
  output reg bvalid_out, // response valid
  output reg [1:0] bresp_out, // response code
  input wire bready_in, // response ready
  input wire [1:0] resp_in, // response for the captured address
  output reg wr_go_out, // one-cycle commit pulse
  output reg [`PLDC_AW-1:0] wr_addr_out, // captured address
  output reg [31:0] wr_data_out, // captured data
  output reg [3:0] wr_strb_out // captured strobes
);
  reg have_a_ff;
  reg have_d_ff;
  wire take_a = awvalid_in & awready_out;
  wire take_d = wvalid_in & wready_out;
  wire a_ok = have_a_ff | take_a;
  wire d_ok = have_d_ff | take_d;

  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      have_a_ff <= 1'b0;
      have_d_ff <= 1'b0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= `PLDC_RESP_OKAY;
      wr_go_out <= 1'b0;
      wr_addr_out <= {`PLDC_AW{1'b0}};
      wr_data_out <= 32'h00000000;
      wr_strb_out <= 4'h0;
    end else begin
      wr_go_out <= 1'b0;
      if (take_a) begin
        wr_addr_out <= awaddr_in;
      end
      if (take_d) begin
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (bvalid_out) begin
        awready_out <= 1'b0;
        wready_out <= 1'b0;
        if (bready_in) begin
          bvalid_out <= 1'b0;
        end
      end else if (a_ok && d_ok && !wr_go_out) begin
        have_a_ff <= 1'b0;
        have_d_ff <= 1'b0;
        awready_out <= 1'b0;
        wready_out <= 1'b0;
        wr_go_out <= 1'b1;
      end else begin
        have_a_ff <= a_ok;
        have_d_ff <= d_ok;
        awready_out <= !a_ok && !wr_go_out;
        wready_out <= !d_ok && !wr_go_out;
      end
      // response one cycle after commit, address decoded by parent
      if (wr_go_out) begin
        bvalid_out <= 1'b1;
        bresp_out <= resp_in;
      end
    end
  end
endmodule

// file: pldc_io_cfg.v
`timescale 1ns/1ns
`include "pldc_map.vh"
module pldc_io_cfg (
  input wire ref_clk_in, // system clock, 50 mhz
  input wire rstn_in, // synchronous reset, active low
  input wire [`PLDC_AW-1:0] awaddr_in, // axi write address
  input wire awvalid_in, // axi write address valid
  output wire awready_out, // axi write address ready
  input wire [31:0] wdata_in, // axi write data
  input wire [3:0] wstrb_in, // axi write strobes
  input wire wvalid_in, // axi write data valid
  output wire wready_out, // axi write data ready
  output wire bvalid_out, // axi write response valid
  output wire [1:0] bresp_out, // axi write response
  input wire bready_in, // axi write response ready
  input wire [`PLDC_AW-1:0] araddr_in, // axi read address
  input wire arvalid_in, // axi read address valid
  output reg arready_out, // axi read address ready
  output reg [31:0] rdata_out, // axi read data
  output reg [1:0] rresp_out, // axi read response
  output reg rvalid_out, // axi read data valid
  input wire rready_in, // axi read data ready
  output reg [31:0] open_drain_out, // per line: 1 = drive low only
  output reg [31:0] pullup_on_out, // per line: 1 = pull-up resistor on
  output reg [31:0] periph_b_out, // per line: 1 = peripheral b, 0 = a
  output reg [31:0] level_out, // per line drive level
  output reg [31:0] pad_oe_out // per line pad output enable
);
  wire wr_go;
  wire [`PLDC_AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [31:0] od_state;
  wire [31:0] pu_state;
  wire [31:0] pb_state;
  wire [31:0] dw_state;
  reg [31:0] level_ff;
  reg [31:0] nxt_level;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function is_mapped;
    input [`PLDC_AW-1:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `PLDC_OFS_OUT_LVL);
    end
  endfunction

  // every operand is an argument, so the masks follow each commit pulse
  function [31:0] hit_mask;
    input go;
    input [`PLDC_AW-1:0] a;
    input [`PLDC_AW-1:0] ofs;
    input [31:0] d;
    input [3:0] s;
    begin
      hit_mask = (go && a == ofs) ? lane_data(d, s) : 32'h00000000;
    end
  endfunction

  function [31:0] lane_data;
    input [31:0] d;
    input [3:0] s;
    begin
      lane_data = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  wire [1:0] wr_resp = is_mapped(wr_addr) ? `PLDC_RESP_OKAY : `PLDC_RESP_SLVERR;
  wire [31:0] od_set = hit_mask(wr_go, wr_addr, `PLDC_OFS_OD_EN, wr_data, wr_strb);
  wire [31:0] od_clr = hit_mask(wr_go, wr_addr, `PLDC_OFS_OD_DIS, wr_data, wr_strb);
  wire [31:0] pu_set = hit_mask(wr_go, wr_addr, `PLDC_OFS_PU_EN, wr_data, wr_strb);
  wire [31:0] pu_clr = hit_mask(wr_go, wr_addr, `PLDC_OFS_PU_DIS, wr_data, wr_strb);
  wire [31:0] pb_set = hit_mask(wr_go, wr_addr, `PLDC_OFS_PB_SEL, wr_data, wr_strb);
  wire [31:0] pb_clr = hit_mask(wr_go, wr_addr, `PLDC_OFS_PA_SEL, wr_data, wr_strb);
  wire [31:0] dw_set = hit_mask(wr_go, wr_addr, `PLDC_OFS_DW_EN, wr_data, wr_strb);
  wire [31:0] dw_clr = hit_mask(wr_go, wr_addr, `PLDC_OFS_DW_DIS, wr_data, wr_strb);

  pldc_axil_wr u_wr (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bvalid_out(bvalid_out),
    .bresp_out(bresp_out),
    .bready_in(bready_in),
    .resp_in(wr_resp),
    .wr_go_out(wr_go),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb)
  );

  // ----------------------------------------
  // configuration state, one bit per line
  // ----------------------------------------
  // line mapping
  pldc_setclr #(.RST_VAL(`PLDC_RST_OD)) u_od (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .set_in(od_set),
    .clr_in(od_clr),
    .state_out(od_state)
  );

  pldc_setclr #(.RST_VAL(`PLDC_RST_PU_ON)) u_pu (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .set_in(pu_set),
    .clr_in(pu_clr),
    .state_out(pu_state)
  );

  pldc_setclr #(.RST_VAL(`PLDC_RST_PB)) u_pb (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .set_in(pb_set),
    .clr_in(pb_clr),
    .state_out(pb_state)
  );

  pldc_setclr #(.RST_VAL(`PLDC_RST_DW)) u_dw (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .set_in(dw_set),
    .clr_in(dw_clr),
    .state_out(dw_state)
  );

  // ----------------------------------------
  // output level value
  // ----------------------------------------
  always @* begin
    nxt_level = level_ff;
    if (wr_go && wr_addr == `PLDC_OFS_OUT_LVL) begin
      nxt_level = (level_ff & ~dw_state) | (lane_data(wr_data, wr_strb) & dw_state)
        | (level_ff & dw_state & ~{{8{wr_strb[3]}}, {8{wr_strb[2]}},
        {8{wr_strb[1]}}, {8{wr_strb[0]}}});
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      level_ff <= `PLDC_RST_LVL;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // ----------------------------------------
  // pad-facing outputs
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      open_drain_out <= `PLDC_RST_OD;
      pullup_on_out <= `PLDC_RST_PU_ON;
      periph_b_out <= `PLDC_RST_PB;
      level_out <= `PLDC_RST_LVL;
      pad_oe_out <= 32'hffffffff;
    end else begin
      open_drain_out <= od_state;
      pullup_on_out <= pu_state;
      periph_b_out <= pb_state;
      level_out <= level_ff;
      pad_oe_out <= ~od_state | ~level_ff;
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (araddr_in)
      `PLDC_OFS_OD_STAT: rd_val = od_state;
      `PLDC_OFS_PU_STAT: rd_val = ~pu_state;
      `PLDC_OFS_PAB_STAT: rd_val = pb_state;
      `PLDC_OFS_DW_STAT: rd_val = dw_state;
      `PLDC_OFS_OUT_LVL: rd_val = level_ff;
      default: rd_val = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h00000000;
      rresp_out <= `PLDC_RESP_OKAY;
    end else begin
      if (rvalid_out) begin
        arready_out <= 1'b0;
        if (rready_in) begin
          rvalid_out <= 1'b0;
        end
      end else if (arvalid_in && arready_out) begin
        arready_out <= 1'b0;
        rvalid_out <= 1'b1;
        rdata_out <= rd_val;
        rresp_out <= is_mapped(araddr_in) ? `PLDC_RESP_OKAY : `PLDC_RESP_SLVERR;
      end else begin
        arready_out <= 1'b1;
      end
    end
  end
endmodule

// file: pldc_io_cfg_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module pldc_io_cfg_checker (
  input wire ref_clk_in, // clock
  input wire rstn_in, // reset, active low
  input wire awvalid_in, // aw valid
  input wire awready_out, // aw ready
  input wire wvalid_in, // w valid
  input wire wready_out, // w ready
  input wire bvalid_out, // b valid
  input wire bready_in, // b ready
  input wire arvalid_in, // ar valid
  input wire arready_out, // ar ready
  input wire rvalid_out, // r valid
  input wire rready_in, // r ready
  input wire [31:0] rdata_out, // read data
  input wire [31:0] open_drain_out, // open-drain lines
  input wire [31:0] pullup_on_out, // pull-up lines
  input wire [31:0] periph_b_out, // peripheral b lines
  input wire [31:0] level_out, // drive levels
  input wire [31:0] pad_oe_out // pad enables
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  a_pad_oe_rel: assert property (pad_oe_out == (~open_drain_out | ~level_out))
    else $error("pad enable wrong");
  a_wr_answer: assert property (awvalid_in && awready_out && wvalid_in && wready_out
    |=> ##1 bvalid_out)
    else $error("write answer late");
  a_rd_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read answer late");
  a_b_hold: assert property (bvalid_out && !bready_in |=> bvalid_out)
    else $error("bvalid dropped");
  a_r_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("rvalid or rdata moved");
  a_aw_block: assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("write taken while busy");
  a_ar_block: assert property (rvalid_out |-> !arready_out)
    else $error("read taken while busy");
  a_cfg_by_write: assert property ($changed({open_drain_out, pullup_on_out, periph_b_out,
    level_out}) |-> $past(bvalid_out))
    else $error("line config moved without write");
  cover property (bvalid_out && !bready_in);
  cover property (rvalid_out && !rready_in);
  cover property (pad_oe_out != 32'hffffffff);
endmodule
bind pldc_io_cfg pldc_io_cfg_checker u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
  .awvalid_in(awvalid_in), .awready_out(awready_out), .wvalid_in(wvalid_in),
  .wready_out(wready_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
  .arvalid_in(arvalid_in), .arready_out(arready_out), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .rdata_out(rdata_out), .open_drain_out(open_drain_out),
  .pullup_on_out(pullup_on_out), .periph_b_out(periph_b_out), .level_out(level_out),
  .pad_oe_out(pad_oe_out));

// file: pldc_pad_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// pad wire model
// ----------------------------------------
module pldc_pad_model (
  input wire ref_clk_in, // clock
  input wire [31:0] level_in, // drive level
  input wire [31:0] oe_in, // pad driven
  input wire [31:0] pullup_in, // pull-up on
  output wire [31:0] pad_out // resolved wire level
);
  logic tgl_ff = 1'b0;
  always @(posedge ref_clk_in) begin
    tgl_ff <= ~tgl_ff;
  end
  assign pad_out = (oe_in & level_in) | (~oe_in & pullup_in) |
    (~oe_in & ~pullup_in & {32{tgl_ff}});
endmodule

// file: tb_pldc_io_cfg.sv
`timescale 1ns/1ns
`include "pldc_map.vh"
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_pldc_io_cfg;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0] wstrb_in = 4'h0;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic arvalid_in = 1'b0, rready_in = 1'b0;
  wire awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  wire [1:0] bresp_out, rresp_out;
  wire [31:0] rdata_out, open_drain_out, pullup_on_out, periph_b_out, level_out;
  wire [31:0] pad_oe_out, pad_w;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  localparam [1:0] OK = `PLDC_RESP_OKAY;
  localparam [1:0] ER = `PLDC_RESP_SLVERR;
  pldc_io_cfg dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out), .wdata_in(wdata_in),
    .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out),
    .bvalid_out(bvalid_out), .bresp_out(bresp_out), .bready_in(bready_in),
    .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
    .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
    .rready_in(rready_in), .open_drain_out(open_drain_out), .pullup_on_out(pullup_on_out),
    .periph_b_out(periph_b_out), .level_out(level_out), .pad_oe_out(pad_oe_out));
  pldc_pad_model pads (.ref_clk_in(ref_clk_in), .level_in(level_out), .oe_in(pad_oe_out),
    .pullup_in(pullup_on_out), .pad_out(pad_w));
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  task results;
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // slow answers hold the ready low for one cycle after valid shows
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er, input st);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge ref_clk_in);
    awaddr_in <= a;
    wdata_in <= d;
    wstrb_in <= s;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= !st;
    while (!ad || !dd) begin
      @(posedge ref_clk_in);
      if (!ad && awready_out === 1'b1) begin
        ad = 1;
        awvalid_in <= 1'b0;
      end
      if (!dd && wready_out === 1'b1) begin
        dd = 1;
        wvalid_in <= 1'b0;
      end
    end
    do @(posedge ref_clk_in); while (bvalid_out !== 1'b1);
    if (st) begin
      bready_in <= 1'b1;
      @(posedge ref_clk_in);
    end
    bready_in <= 1'b0;
    chk({30'h0, bresp_out}, {30'h0, er});
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er, input st);
    @(posedge ref_clk_in);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= !st;
    do @(posedge ref_clk_in); while (arready_out !== 1'b1);
    arvalid_in <= 1'b0;
    do @(posedge ref_clk_in); while (rvalid_out !== 1'b1);
    if (st) begin
      rready_in <= 1'b1;
      @(posedge ref_clk_in);
    end
    rready_in <= 1'b0;
    if (er == OK) chk(rdata_out, e);
    chk({30'h0, rresp_out}, {30'h0, er});
  endtask
  task t_rst;
    rd(`PLDC_OFS_OD_STAT, 32'h0, OK, 0);
    rd(`PLDC_OFS_PU_STAT, 32'h0, OK, 0);
    rd(`PLDC_OFS_PAB_STAT, 32'h0, OK, 0);
    rd(`PLDC_OFS_DW_STAT, 32'h0, OK, 0);
    chk(pad_oe_out, 32'hffffffff);
  endtask
  task t_od;
    wr(`PLDC_OFS_OD_EN, 32'h80000001, 4'hf, OK, 1);
    wr(`PLDC_OFS_OD_DIS, 32'h00000001, 4'hf, OK, 0);
    rd(`PLDC_OFS_OD_STAT, 32'h80000000, OK, 0);
    chk(open_drain_out, 32'h80000000);
  endtask
  task t_pu;
    wr(`PLDC_OFS_PU_DIS, 32'h0000ff00, 4'hf, OK, 0);
    wr(`PLDC_OFS_PU_EN, 32'h00000f00, 4'hf, OK, 0);
    rd(`PLDC_OFS_PU_STAT, 32'h0000f000, OK, 0);
    wr(`PLDC_OFS_PU_DIS, 32'hffffffff, 4'b0100, OK, 0);
    rd(`PLDC_OFS_PU_STAT, 32'h00fff000, OK, 0);
    chk(pullup_on_out, 32'hff000fff);
  endtask
  task t_per;
    wr(`PLDC_OFS_PB_SEL, 32'h00ff00ff, 4'hf, OK, 0);
    wr(`PLDC_OFS_PA_SEL, 32'h0000000f, 4'hf, OK, 0);
    rd(`PLDC_OFS_PAB_STAT, 32'h00ff00f0, OK, 1);
    chk(periph_b_out, 32'h00ff00f0);
  endtask
  task t_dw;
    wr(`PLDC_OFS_OUT_LVL, 32'hffffffff, 4'hf, OK, 0);
    rd(`PLDC_OFS_OUT_LVL, 32'h0, OK, 0);
    wr(`PLDC_OFS_DW_EN, 32'h80000003, 4'hf, OK, 0);
    rd(`PLDC_OFS_DW_STAT, 32'h80000003, OK, 0);
    wr(`PLDC_OFS_OUT_LVL, 32'hffffffff, 4'hf, OK, 0);
    rd(`PLDC_OFS_OUT_LVL, 32'h80000003, OK, 0);
    chk(pad_oe_out, 32'h7fffffff);
    chk(pad_w, 32'h80000003);
    wr(`PLDC_OFS_DW_DIS, 32'h00000001, 4'hf, OK, 0);
    rd(`PLDC_OFS_DW_STAT, 32'h80000002, OK, 0);
    wr(`PLDC_OFS_OUT_LVL, 32'h0, 4'hf, OK, 0);
    rd(`PLDC_OFS_OUT_LVL, 32'h00000001, OK, 0);
    chk(level_out, 32'h00000001);
  endtask
  task t_err;
    wr(8'h34, 32'hffffffff, 4'hf, ER, 0);
    wr(8'h05, 32'hffffffff, 4'hf, ER, 0);
    rd(8'h34, 32'h0, ER, 0);
    rd(`PLDC_OFS_OD_DIS, 32'h0, OK, 0);
    rd(`PLDC_OFS_OD_STAT, 32'h80000000, OK, 0);
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_rst;
    t_od;
    t_pu;
    t_per;
    t_dw;
    t_err;
    results;
  end
endmodule
